/* ast_uart_tx.sv */
`timescale 1ns/1ps
`include "ast_params.svh"
module ast_uart_tx
	import ast_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [11:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	output logic             o_tx,
	output logic             o_tx_oe,
	output logic             o_irq
);
	logic [7:0]  txcs;      // Transmit control/status (writable bits)
	logic [7:0]  rxcs;      // Receive control/status
	logic [7:0]  baudc;     // Baud control
	logic [15:0] divisor;   // Baud divisor pair
	logic [7:0]  intc;      // Interrupt enables
	logic [7:0]  hold;      // Holding register
	logic        hold_full; // Holding register occupied
	logic        hold_bit9; // Ninth bit latched with holding write
	logic        hold_empty; // Holding-empty flag
	logic        irq_stat;  // Sticky interrupt status
	logic        irq_mask;  // Interrupt mask
	logic        wr;        // Write completes this edge
	logic        busy;      // Shifter active
	logic        line;      // Raw serial level
	logic        load;      // Move holding to shifter
	logic        tx_on;     // Transmitter enabled and port on
	logic        hold_empty_set; // Flag set event

	ast_tick_if tk ();

	assign wr        = i_psel && i_penable && i_pwrite;
	assign o_pready  = 1'b1;  // Zero-wait slave
	assign tx_on     = txcs[`AST_TX_EN_BIT] && rxcs[`AST_PORT_EN_BIT];
	assign load      = hold_full && !busy && tx_on;
	// Pin released when disabled, left to general purpose logic
	assign o_tx_oe   = tx_on;
	assign o_tx      = tx_on ? (line ^ baudc[`AST_INVERT_BIT]) : 1'b0;

	// Unmapped addresses error; shift register has no address
	always_comb begin
		unique case (i_paddr)
			`AST_TXCS_ADDR, `AST_RXCS_ADDR, `AST_BAUDC_ADDR, `AST_DIVL_ADDR,
			`AST_DIVH_ADDR, `AST_HOLD_ADDR, `AST_RXDATA_ADDR, `AST_INTC_ADDR,
			`AST_IRQ_ADDR: o_pslverr = 1'b0;
			default:       o_pslverr = i_psel && i_penable;
		endcase
	end

	// Configuration registers
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			txcs    <= `AST_CTRL_RST;
			rxcs    <= `AST_CTRL_RST;
			baudc   <= `AST_CTRL_RST;
			divisor <= `AST_DIV_RST;
			intc    <= `AST_CTRL_RST;
			irq_mask <= 1'b0;
		end else if (wr) begin
			unique case (i_paddr)
				`AST_TXCS_ADDR:  txcs  <= i_pwdata[7:0] & 8'hFD;  // Status bit read-only
				`AST_RXCS_ADDR:  rxcs  <= i_pwdata[7:0];
				`AST_BAUDC_ADDR: baudc <= i_pwdata[7:0];
				`AST_DIVL_ADDR:  divisor[7:0]  <= i_pwdata[7:0];
				`AST_DIVH_ADDR:  divisor[15:8] <= i_pwdata[7:0];
				`AST_INTC_ADDR:  intc  <= i_pwdata[7:0];
				`AST_IRQ_ADDR:   irq_mask <= i_pwdata[8];
				default: ;
			endcase
		end
	end

	// Holding register; ninth bit captured from its control bit at write time
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			hold      <= 8'h00;
			hold_bit9 <= 1'b0;
			hold_full <= 1'b0;
		end else if (wr && i_paddr == `AST_HOLD_ADDR) begin
			hold      <= i_pwdata[7:0];
			hold_bit9 <= txcs[`AST_NINTH_BIT] && txcs[`AST_NINE_EN_BIT];
			hold_full <= 1'b1;
		end else if (load || !tx_on) begin
			hold_full <= 1'b0;  // Disabling drops a pending byte
		end
	end

	// Holding-empty flag: set on enable and on transfer, cleared by new write
	assign hold_empty_set = load || (tx_on && !hold_full && !hold_empty);
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			hold_empty <= 1'b0;
		end else if (!tx_on) begin
			hold_empty <= 1'b0;
		end else if (hold_empty_set) begin
			hold_empty <= 1'b1;
		end else if (wr && i_paddr == `AST_HOLD_ADDR) begin
			hold_empty <= 1'b0;
		end
	end

	// Sticky status; set wins over write-one clear
	always_ff @(posedge i_clk) begin
		if (!i_rst_n)
			irq_stat <= 1'b0;
		else if (hold_empty_set && tx_on)
			irq_stat <= 1'b1;
		else if (wr && i_paddr == `AST_IRQ_ADDR && i_pwdata[`AST_IRQ_STAT_BIT])
			irq_stat <= 1'b0;
	end

	// Level interrupt: flag gated by three enables, or masked sticky bit
	always_ff @(posedge i_clk) begin
		if (!i_rst_n)
			o_irq <= 1'b0;
		else
			o_irq <= (hold_empty && intc[`AST_TX_IE_BIT] && intc[`AST_PERIPH_IE_BIT]
			          && intc[`AST_GLOBAL_IE_BIT]) || (irq_stat && irq_mask);
	end

	// Read mux, registered-free; reads need no side effects
	always_comb begin
		o_prdata = 32'h0000_0000;
		unique case (i_paddr)
			`AST_TXCS_ADDR:  o_prdata[7:0] = {txcs[7:2], !busy && !load, txcs[0]};
			`AST_RXCS_ADDR:  o_prdata[7:0] = rxcs;
			`AST_BAUDC_ADDR: o_prdata[7:0] = baudc;
			`AST_DIVL_ADDR:  o_prdata[7:0] = divisor[7:0];
			`AST_DIVH_ADDR:  o_prdata[7:0] = divisor[15:8];
			`AST_INTC_ADDR:  o_prdata[7:0] = {intc[7:1], hold_empty};
			`AST_IRQ_ADDR:   o_prdata[8:0] = {irq_mask, 7'h00, irq_stat};
			default:         o_prdata = 32'h0000_0000;
		endcase
	end

	ast_baud u_baud (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_div   (divisor),
		.i_high_speed (txcs[`AST_HSPEED_BIT]),
		.i_wide_div   (baudc[`AST_WIDE_DIV_BIT]),
		.tk      (tk)
	);

	ast_shift u_shift (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_load  (load),
		.i_data  ({hold_bit9, hold}),
		.i_nine  (txcs[`AST_NINE_EN_BIT]),
		.i_abort (!tx_on),
		.o_busy  (busy),
		.o_line  (line),
		.tk      (tk)
	);
endmodule : ast_uart_tx

/* ast_params.svh */
`ifndef AST_PARAMS_SVH
`define AST_PARAMS_SVH

// Register byte addresses
`define AST_TXCS_ADDR    12'h000
`define AST_RXCS_ADDR    12'h004
`define AST_BAUDC_ADDR   12'h008
`define AST_DIVL_ADDR    12'h00C
`define AST_DIVH_ADDR    12'h010
`define AST_HOLD_ADDR    12'h014
`define AST_RXDATA_ADDR  12'h018
`define AST_INTC_ADDR    12'h01C
`define AST_IRQ_ADDR     12'h020

// Transmit control/status fields
`define AST_NINE_EN_BIT     6
`define AST_TX_EN_BIT       5
`define AST_SYNC_BIT        4
`define AST_HSPEED_BIT      2
`define AST_SHIFT_EMPTY_BIT 1
`define AST_NINTH_BIT       0
// Receive control/status fields
`define AST_PORT_EN_BIT     7
// Baud control fields
`define AST_INVERT_BIT      4
`define AST_WIDE_DIV_BIT    3
// Interrupt control fields
`define AST_GLOBAL_IE_BIT   7
`define AST_PERIPH_IE_BIT   6
`define AST_TX_IE_BIT       4
// Interrupt status bit (sticky)
`define AST_IRQ_STAT_BIT    0

// Reset values
`define AST_TXCS_RST     8'h02
`define AST_CTRL_RST     8'h00
`define AST_DIV_RST      16'h0000

// Sub-bit prescale limits, minus one: 64x, 16x, 4x
`define AST_SUB_X64      6'h3F
`define AST_SUB_X16      6'h0F
`define AST_SUB_X4       6'h03

`endif

/* ast_pkg.sv */
package ast_pkg;
	// Transmit sequencer states
	typedef enum logic [1:0] {
		AST_IDLE  = 2'b00,
		AST_START = 2'b01,
		AST_DATA  = 2'b10,
		AST_STOP  = 2'b11
	} ast_state_type;
endpackage : ast_pkg

/* ast_tick_if.sv */
`timescale 1ns/1ps
// Bit-tick link between baud generator and shifter
interface ast_tick_if;
	logic        tick;  // One bit time elapsed
	logic        run;   // Generator running
	modport gen (output tick, input run);
	modport use_ (input tick, output run);
endinterface : ast_tick_if

/* ast_baud.sv */
`timescale 1ns/1ps
`include "ast_params.svh"
module ast_baud
	import ast_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	input  wire logic [15:0] i_div,
	input  wire logic        i_high_speed,
	input  wire logic        i_wide_div,
	ast_tick_if.gen          tk
);
	logic [15:0] pre_cnt;  // Divisor counter
	logic [5:0]  sub_cnt;  // Sub-bit prescaler
	logic [15:0] div_eff;  // Divisor in use
	logic [5:0]  sub_max;  // Prescale limit minus one

	// Eight-bit mode uses only the low byte
	always_comb begin
		div_eff = i_wide_div ? i_div : {8'h00, i_div[7:0]};
		// 64x, 16x or 4x per bit depending on the selects
		if (i_high_speed && i_wide_div)
			sub_max = `AST_SUB_X4;
		else if (i_high_speed || i_wide_div)
			sub_max = `AST_SUB_X16;
		else
			sub_max = `AST_SUB_X64;
	end

	// Counter n+1 then prescaler; restarts with each frame for clean edges
	always_ff @(posedge i_clk) begin
		if (!i_rst_n || !tk.run) begin
			pre_cnt <= 16'h0000;
			sub_cnt <= 6'h00;
		end else if (pre_cnt >= div_eff) begin
			pre_cnt <= 16'h0000;
			sub_cnt <= (sub_cnt >= sub_max) ? 6'h00 : sub_cnt + 6'h01;
		end else begin
			pre_cnt <= pre_cnt + 16'h0001;
		end
	end

	// Bit tick when both stages wrap
	assign tk.tick = tk.run && (pre_cnt >= div_eff) && (sub_cnt >= sub_max);
endmodule : ast_baud

/* ast_shift.sv */
`timescale 1ns/1ps
`include "ast_params.svh"
module ast_shift
	import ast_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_load,
	input  wire logic [8:0] i_data,
	input  wire logic       i_nine,
	input  wire logic       i_abort,
	output logic            o_busy,
	output logic            o_line,
	ast_tick_if.use_        tk
);
	ast_state_type state;   // Frame phase
	logic [8:0]    shreg;   // Shift register, unmapped
	logic [3:0]    bit_cnt; // Data bits left minus one

	assign o_busy = (state != AST_IDLE);
	assign tk.run = o_busy;

	// Frame sequencer
	always_ff @(posedge i_clk) begin
		if (!i_rst_n || i_abort) begin
			state   <= AST_IDLE;
			shreg   <= 9'h000;
			bit_cnt <= 4'h0;
			o_line  <= 1'b1;
		end else begin
			unique case (state)
				AST_IDLE: begin
					o_line <= 1'b1;
					if (i_load) begin
						shreg   <= i_data;
						bit_cnt <= i_nine ? 4'h8 : 4'h7;
						o_line  <= 1'b0;
						state   <= AST_START;
					end
				end
				AST_START: if (tk.tick) begin
					o_line <= shreg[0];
					shreg  <= {1'b0, shreg[8:1]};
					state  <= AST_DATA;
				end
				AST_DATA: if (tk.tick) begin
					if (bit_cnt == 4'h0) begin
						o_line <= 1'b1;
						state  <= AST_STOP;
					end else begin
						o_line  <= shreg[0];
						shreg   <= {1'b0, shreg[8:1]};
						bit_cnt <= bit_cnt - 4'h1;
					end
				end
				AST_STOP: if (tk.tick) begin
					state <= AST_IDLE;
				end
			endcase
		end
	end
endmodule : ast_shift

/* ast_uart_tx_properties.sv */
`timescale 1ns/1ps
module ast_uart_tx_properties (
	input wire logic        i_clk,
	input wire logic        i_rst_n,
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [31:0] o_prdata,
	input wire logic        o_pready,
	input wire logic        o_pslverr,
	input wire logic        o_tx,
	input wire logic        o_tx_oe,
	input wire logic        o_irq
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// Read and write access phases
	wire rd_a = i_psel & i_penable & !i_pwrite;
	wire wr_a = i_psel & i_penable & i_pwrite;
	AST_READY: assert property (i_psel |-> o_pready) else $error("no ready");
	AST_UNMAP: assert property (rd_a && i_paddr > 12'h020 |-> o_pslverr && o_prdata == 0)
		else $error("unmapped ok");
	AST_HOLD_RD: assert property (rd_a && i_paddr == 12'h014 |-> o_prdata == 0) else $error("shift seen");
	AST_RXD_RD: assert property (rd_a && i_paddr == 12'h018 |-> o_prdata == 0) else $error("rx data");
	AST_PIN_OFF: assert property (!o_tx_oe |-> !o_tx) else $error("pin held");
	AST_PORT_DIS: assert property (wr_a && i_paddr == 12'h004 && !i_pwdata[7] |-> ##[1:2] !o_tx_oe)
		else $error("port off");
	AST_TX_DIS: assert property (wr_a && i_paddr == 12'h000 && !i_pwdata[5] |-> ##[1:2] !o_tx_oe)
		else $error("tx off");
	AST_OE_SRC: assert property ($rose(o_tx_oe) |-> $past(wr_a) || $past(wr_a, 2))
		else $error("oe no cause");
	// Main scenarios reached
	C_IRQ: cover property ($rose(o_irq));
	C_FRAME: cover property (o_tx_oe && $fell(o_tx));
	C_OE: cover property ($rose(o_tx_oe));
	C_ERR: cover property (o_pslverr);
endmodule : ast_uart_tx_properties
bind ast_uart_tx ast_uart_tx_properties i_props (.*);

/* ast_rx_model.sv */
`timescale 1ns/1ps
// Remote receiver: samples mid bit, counts frames
module ast_rx_model (
	input wire logic        i_clk,
	input wire logic        i_line,
	input wire logic        i_oe,
	input wire logic        i_inv,
	input wire logic        i_nine,
	input wire logic [31:0] i_bit,
	output logic      [8:0] o_data,
	output logic            o_ok,
	output int              o_cnt
);
	wire l = i_line ^ i_inv; // Undo inversion
	initial begin
		o_cnt = 0;
		o_data = 9'h000;
		o_ok = 1'b0;
		forever begin
			// Start bit low, only while pin driven
			@(posedge i_clk iff (i_oe && !l));
			repeat (i_bit / 2) @(posedge i_clk);
			o_data = 9'h000;
			// LSB first, ninth last
			for (int k = 0; k < (i_nine ? 9 : 8); k++) begin
				repeat (i_bit) @(posedge i_clk);
				o_data[k] = l;
			end
			repeat (i_bit) @(posedge i_clk);
			o_ok = l; // Stop high
			o_cnt++;
		end
	end
endmodule : ast_rx_model

/* test_async_serial_transmitter.sv */
`timescale 1ns/1ps
module test_async_serial_transmitter;
	logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic pready, pslverr, tx, oe, irq, er, rx_ok, inv = 0, nine = 0;
	logic [8:0] rx_d;
	int rx_n, failures = 0, checked = 0;
	always #2 clk = ~clk;
	ast_uart_tx i_dut (.i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .o_tx(tx), .o_tx_oe(oe), .o_irq(irq));
	// Bit time (1+1)*4 clocks
	ast_rx_model i_rx (.i_clk(clk), .i_line(tx), .i_oe(oe), .i_inv(inv), .i_nine(nine), .i_bit(8),
		.o_data(rx_d), .o_ok(rx_ok), .o_cnt(rx_n));
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask : chk
	// One APB transfer, idle cycle after
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic wait_rx(input int n, input logic [8:0] e);
		repeat (400) if (rx_n != n) @(posedge clk);
		chk("frames", n, rx_n);
		chk("rx data", e, rx_d);
		chk("stop", 1, rx_ok);
	endtask : wait_rx
	task automatic t_enable();
		apb(0, 12'h000, 0);
		chk("txctl", 32'h0000_0002, rd);
		apb(0, 12'h024, 0);
		chk("slverr", 1, er);
		apb(0, 12'h014, 0);
		chk("hold read", 0, rd);
		apb(0, 12'h018, 0);
		chk("rx data read", 0, rd);
		apb(1, 12'h00C, 32'h0000_0001);
		apb(1, 12'h010, 0);
		apb(1, 12'h008, 32'h0000_0008);
		apb(1, 12'h004, 32'h0000_0080);
		apb(1, 12'h000, 32'h0000_0024);
		chk("oe on", 1, oe);
		apb(0, 12'h01C, 0);
		chk("hold empty", 1, rd[0]);
		apb(1, 12'h01C, 32'h0000_00D0);
		repeat (2) @(posedge clk);
		chk("irq on", 1, irq);
		apb(1, 12'h01C, 32'h0000_0050);
		repeat (2) @(posedge clk);
		chk("irq gated", 0, irq);
	endtask : t_enable
	task automatic t_frames();
		apb(1, 12'h014, 32'h0000_00A5);
		apb(0, 12'h000, 0);
		chk("shift empty busy", 0, rd[1]);
		wait_rx(1, 9'h0A5);
		repeat (8) @(posedge clk);
		apb(0, 12'h000, 0);
		chk("shift empty idle", 1, rd[1]);
		nine = 1;
		apb(1, 12'h000, 32'h0000_0065);
		apb(1, 12'h014, 32'h0000_003C);
		wait_rx(2, 9'h13C);
		nine = 0;
		apb(1, 12'h000, 32'h0000_0024);
		apb(1, 12'h014, 32'h0000_0011);
		apb(1, 12'h014, 32'h0000_0022);
		apb(0, 12'h01C, 0);
		chk("hold empty full", 0, rd[0]);
		wait_rx(3, 9'h011);
		wait_rx(4, 9'h022);
	endtask : t_frames
	task automatic t_invert();
		apb(1, 12'h000, 32'h0000_0004);
		inv = 1;
		apb(1, 12'h008, 32'h0000_0018);
		apb(1, 12'h000, 32'h0000_0024);
		chk("inv idle", 0, tx);
		apb(1, 12'h014, 32'h0000_0081);
		wait_rx(5, 9'h081);
	endtask : t_invert
	task automatic t_irq();
		apb(1, 12'h020, 32'h0000_0100);
		repeat (2) @(posedge clk);
		chk("irq mask", 1, irq);
		apb(1, 12'h000, 32'h0000_0004);
		chk("pin off", 0, oe);
		chk("pin low", 0, tx);
		apb(1, 12'h020, 32'h0000_0101);
		apb(0, 12'h020, 0);
		chk("status", 32'h0000_0100, rd);
		repeat (2) @(posedge clk);
		chk("irq clr", 0, irq);
		apb(1, 12'h004, 0);
	endtask : t_irq
	task automatic give_verdict();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : give_verdict
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_enable();
		t_frames();
		t_invert();
		t_irq();
		give_verdict();
	end
	// Run needs about 500 cycles
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		give_verdict();
	end
endmodule : test_async_serial_transmitter
